// file: uemr_pkg.sv
package uemr_pkg;
    // ==================================================
    // Register map
    localparam logic [7:0] ADDR_CTL_MODE = 8'h44;
    localparam logic [7:0] ADDR_A_MODE = 8'h45;
    localparam logic [7:0] ADDR_B_MODE = 8'h46;
    localparam logic [7:0] ADDR_CTL_BUF = 8'h50;
    localparam logic [7:0] ADDR_A_BUF = 8'h58;
    localparam logic [7:0] ADDR_B_BUF = 8'h60;
    localparam logic [7:0] MODE_REG_RESET = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    localparam int STALL_BIT = 7;
    localparam int BUF_DEPTH = 8;
    localparam int NUM_EP = 3;
    // ==================================================
    // Mode encodings
    localparam logic [3:0] MODE_DISABLE = 4'h0;
    localparam logic [3:0] MODE_NAK_IN_OUT = 4'h1;
    localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
    localparam logic [3:0] MODE_STALL_IN_OUT = 4'h3;
    localparam logic [3:0] MODE_STATUS_IN = 4'h6;
    localparam logic [3:0] MODE_ACK_OUT_STATUS_IN = 4'hB;
    localparam logic [3:0] MODE_ACK_IN_STATUS_OUT = 4'hF;
    localparam logic [3:0] MODE_NAK_OUT = 4'h8;
    localparam logic [3:0] MODE_ACK_OUT = 4'h9;
    localparam logic [3:0] MODE_NAK_IN = 4'hC;
    localparam logic [3:0] MODE_ACK_IN = 4'hD;
    // ==================================================
    // Packet checks
    localparam logic [4:0] MAX_PKT_LEN = 5'h0A;
    localparam logic [4:0] ZERO_LEN_PKT = 5'h02;
    localparam logic STATUS_TOGGLE = 1'b1;
    localparam logic [3:0] NO_COUNT = 4'h0;
    // ==================================================
    // Types
    typedef enum logic [1:0] {
        TOK_SETUP = 2'b00, TOK_IN = 2'b01, TOK_OUT = 2'b10
    } uemr_tok_type;
    typedef enum logic [1:0] {EP_CTL = 2'b00, EP_A = 2'b01, EP_B = 2'b10} uemr_ep_type;
    typedef enum logic [2:0] {
        RSP_NONE = 3'b000, RSP_ACK = 3'b001, RSP_NAK = 3'b010,
        RSP_STALL = 3'b011, RSP_DATA = 3'b100, RSP_EMPTY = 3'b101
    } uemr_rsp_type;
    typedef struct packed {
        uemr_tok_type kind;
        uemr_ep_type ep;
        logic [4:0] len;
        logic dval;
        logic toggle;
    } uemr_token_type;
    typedef struct packed {
        uemr_rsp_type code;
        logic [3:0] count;
    } uemr_answer_type;
endpackage

// file: uemr_decode.sv
`timescale 1ns/10ps
module uemr_decode (
    // Token and endpoint state
    input wire uemr_pkg::uemr_token_type tok_i,
    input wire logic [3:0] mode_i,
    input wire logic stall_i,
    // Decision
    output uemr_pkg::uemr_rsp_type rsp_o,
    output logic upd_o,
    output logic [3:0] upd_mode_o,
    output logic wait_o,
    output logic [3:0] ack_mode_o
);
    logic ok;
    logic good_status;
    always_comb begin
        ok = (tok_i.len <= uemr_pkg::MAX_PKT_LEN) && tok_i.dval;
        good_status = ok && (tok_i.len == uemr_pkg::ZERO_LEN_PKT)
            && (tok_i.toggle == uemr_pkg::STATUS_TOGGLE);
        rsp_o = uemr_pkg::RSP_NONE;
        upd_o = 1'b0;
        upd_mode_o = uemr_pkg::MODE_DISABLE;
        wait_o = 1'b0;
        ack_mode_o = uemr_pkg::MODE_DISABLE;
        if (tok_i.ep == uemr_pkg::EP_CTL) begin
            if (tok_i.kind == uemr_pkg::TOK_SETUP) begin
                if (ok && (mode_i == uemr_pkg::MODE_NAK_IN_OUT
                    || mode_i == uemr_pkg::MODE_STATUS_OUT
                    || mode_i == uemr_pkg::MODE_STALL_IN_OUT || mode_i == uemr_pkg::MODE_STATUS_IN
                    || mode_i == uemr_pkg::MODE_ACK_OUT_STATUS_IN
                    || mode_i == uemr_pkg::MODE_ACK_IN_STATUS_OUT)) begin
                    rsp_o = uemr_pkg::RSP_ACK;
                    upd_o = 1'b1;
                    upd_mode_o = uemr_pkg::MODE_NAK_IN_OUT;
                end
            end else if (tok_i.kind == uemr_pkg::TOK_IN) begin
                case (mode_i)
                    uemr_pkg::MODE_NAK_IN_OUT: rsp_o = uemr_pkg::RSP_NAK;
                    uemr_pkg::MODE_STATUS_OUT: begin
                        rsp_o = uemr_pkg::RSP_STALL;
                        upd_o = 1'b1;
                        upd_mode_o = uemr_pkg::MODE_STALL_IN_OUT;
                    end
                    uemr_pkg::MODE_STALL_IN_OUT: rsp_o = uemr_pkg::RSP_STALL;
                    uemr_pkg::MODE_STATUS_IN: rsp_o = uemr_pkg::RSP_EMPTY;
                    uemr_pkg::MODE_ACK_OUT_STATUS_IN: rsp_o = uemr_pkg::RSP_EMPTY;
                    uemr_pkg::MODE_ACK_IN_STATUS_OUT: begin
                        rsp_o = uemr_pkg::RSP_DATA;
                        wait_o = 1'b1;
                        ack_mode_o = uemr_pkg::MODE_NAK_IN_OUT;
                    end
                    default: rsp_o = uemr_pkg::RSP_NONE;
                endcase
            end else if (tok_i.kind == uemr_pkg::TOK_OUT && ok) begin
                case (mode_i)
                    uemr_pkg::MODE_NAK_IN_OUT: rsp_o = uemr_pkg::RSP_NAK;
                    uemr_pkg::MODE_STALL_IN_OUT: rsp_o = uemr_pkg::RSP_STALL;
                    uemr_pkg::MODE_STATUS_IN: rsp_o = uemr_pkg::RSP_STALL;
                    uemr_pkg::MODE_ACK_OUT_STATUS_IN: rsp_o = uemr_pkg::RSP_ACK;
                    uemr_pkg::MODE_STATUS_OUT, uemr_pkg::MODE_ACK_IN_STATUS_OUT: begin
                        upd_o = 1'b1;
                        rsp_o = good_status ? uemr_pkg::RSP_ACK : uemr_pkg::RSP_STALL;
                        upd_mode_o = good_status ? uemr_pkg::MODE_STATUS_OUT
                            : uemr_pkg::MODE_STALL_IN_OUT;
                    end
                    default: rsp_o = uemr_pkg::RSP_NONE;
                endcase
            end
        end else if (tok_i.kind == uemr_pkg::TOK_IN) begin
            if (mode_i == uemr_pkg::MODE_NAK_IN) begin
                rsp_o = uemr_pkg::RSP_NAK;
            end else if (mode_i == uemr_pkg::MODE_ACK_IN) begin
                rsp_o = stall_i ? uemr_pkg::RSP_STALL : uemr_pkg::RSP_DATA;
                wait_o = !stall_i;
                ack_mode_o = uemr_pkg::MODE_NAK_IN;
            end
        end else if (tok_i.kind == uemr_pkg::TOK_OUT && ok) begin
            if (mode_i == uemr_pkg::MODE_NAK_OUT) begin
                rsp_o = uemr_pkg::RSP_NAK;
            end else if (mode_i == uemr_pkg::MODE_ACK_OUT) begin
                rsp_o = stall_i ? uemr_pkg::RSP_STALL : uemr_pkg::RSP_ACK;
                upd_o = !stall_i;
                upd_mode_o = uemr_pkg::MODE_NAK_OUT;
            end
        end
    end
endmodule

// file: uemr_buf.sv
`timescale 1ns/10ps
module uemr_buf #(
    parameter int DEPTH = uemr_pkg::BUF_DEPTH,
    parameter int NUM = uemr_pkg::NUM_EP
) (
    // Clock
    input wire logic clk_i,
    // Processor port
    input wire logic cpu_we_i,
    input wire logic [$clog2(NUM*DEPTH)-1:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic [7:0] cpu_rdata_o,
    // Engine port
    input wire logic eng_we_i,
    input wire logic [$clog2(NUM*DEPTH)-1:0] eng_waddr_i,
    input wire logic [7:0] eng_wdata_i,
    input wire logic [$clog2(NUM*DEPTH)-1:0] eng_raddr_i,
    output logic [7:0] eng_rdata_o
);
    // ==================================================
    // Storage, no reset
    logic [7:0] mem [NUM*DEPTH];
    always_ff @(posedge clk_i) begin
        if (cpu_we_i) begin
            mem[cpu_addr_i] <= cpu_wdata_i;
        end
        if (eng_we_i) begin
            mem[eng_waddr_i] <= eng_wdata_i;
        end
    end
    assign cpu_rdata_o = mem[cpu_addr_i];
    assign eng_rdata_o = mem[eng_raddr_i];
endmodule

// file: uemr_top.sv
`timescale 1ns/10ps
// What this block does
// - Engine data-mode write blocks firmware writes to both data modes
// - Engine mode writes beat firmware writes
// - Three eight-byte endpoint buffers
// - Buffer bytes have no reset value
// - Buffers reached only through I/O space
// - Buffers at 0x50, 0x58, 0x60
// - Mode 0000 ignores all tokens
// - Control 0001: accept SETUP, NAK IN/OUT
// - Control 0010: STALL IN, check OUT
// - Control 0011: STALL IN and OUT
// - Control 0110: empty IN, STALL OUT
// - Control 1011: ACK OUT, empty IN
// - Control 1111: counted IN, check OUT
// - Data 1000: NAK OUT only
// - Data 1001: ACK OUT then 1000
// - Data 1100: NAK IN only
// - Data 1101: counted IN then 1100
// - Reserved modes ignore every token
// - Status check: zero length, toggle one
// - Counted IN uses four-bit byte count
// - Accepted SETUP gets ACK
module uemr_top #(
    parameter int DEPTH = uemr_pkg::BUF_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Processor I/O port
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // Token from interface engine
    input wire logic token_valid_i,
    input wire uemr_pkg::uemr_token_type token_i,
    input wire logic host_ack_i,
    // Byte counts from count registers
    input wire logic [3:0] ctl_count_i,
    input wire logic [3:0] a_count_i,
    input wire logic [3:0] b_count_i,
    // Engine buffer access
    input wire logic rx_we_i,
    input wire uemr_pkg::uemr_ep_type rx_ep_i,
    input wire logic [2:0] rx_idx_i,
    input wire logic [7:0] rx_data_i,
    input wire uemr_pkg::uemr_ep_type tx_ep_i,
    input wire logic [2:0] tx_idx_i,
    output logic [7:0] tx_data_o,
    // Answer to engine
    output logic resp_valid_o,
    output uemr_pkg::uemr_answer_type resp_o,
    // Mode state
    output logic [7:0] ctl_mode_o,
    output logic [7:0] a_mode_o,
    output logic [7:0] b_mode_o
);
    localparam int AW = $clog2(uemr_pkg::NUM_EP * DEPTH);
    typedef enum logic {ST_IDLE = 1'b0, ST_WAIT_ACK = 1'b1} uemr_state_type;

    // ==================================================
    // Reset release
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    function automatic logic [AW-1:0] buf_addr(input logic [1:0] ep, input logic [2:0] idx);
        buf_addr = AW'(ep * DEPTH + idx);
    endfunction

    function automatic logic [3:0] sel4(input logic [1:0] ep, input logic [3:0] c,
                                        input logic [3:0] a, input logic [3:0] b);
        if (ep == uemr_pkg::EP_A) begin
            sel4 = a;
        end else if (ep == uemr_pkg::EP_B) begin
            sel4 = b;
        end else begin
            sel4 = c;
        end
    endfunction

    // ==================================================
    // Endpoint selection and decode
    logic [7:0] ctl_mode;
    logic [7:0] a_mode;
    logic [7:0] b_mode;
    logic [3:0] sel_mode;
    logic sel_stall;
    logic [3:0] sel_count;
    uemr_pkg::uemr_rsp_type dec_rsp;
    logic dec_upd;
    logic [3:0] dec_upd_mode;
    logic dec_wait;
    logic [3:0] dec_ack_mode;

    assign sel_mode = sel4(token_i.ep, ctl_mode[3:0], a_mode[3:0], b_mode[3:0]);
    assign sel_stall = (token_i.ep == uemr_pkg::EP_A) ? a_mode[uemr_pkg::STALL_BIT]
        : (token_i.ep == uemr_pkg::EP_B) ? b_mode[uemr_pkg::STALL_BIT] : 1'b0;
    assign sel_count = sel4(token_i.ep, ctl_count_i, a_count_i, b_count_i);

    uemr_decode u_decode (
        .tok_i(token_i),
        .mode_i(sel_mode),
        .stall_i(sel_stall),
        .rsp_o(dec_rsp),
        .upd_o(dec_upd),
        .upd_mode_o(dec_upd_mode),
        .wait_o(dec_wait),
        .ack_mode_o(dec_ack_mode)
    );

    // ==================================================
    // Answer register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid_o <= 1'b0;
            resp_o <= '{code: uemr_pkg::RSP_NONE, count: uemr_pkg::NO_COUNT};
        end else begin
            resp_valid_o <= token_valid_i;
            if (token_valid_i) begin
                resp_o.code <= dec_rsp;
                resp_o.count <= (dec_rsp == uemr_pkg::RSP_DATA) ? sel_count
                    : uemr_pkg::NO_COUNT;
            end
        end
    end

    // ==================================================
    // Host handshake wait after data
    uemr_state_type state;
    uemr_pkg::uemr_ep_type pend_ep;
    logic [3:0] pend_mode;
    logic ack_fire;
    assign ack_fire = (state == ST_WAIT_ACK) && host_ack_i && !token_valid_i;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            pend_ep <= uemr_pkg::EP_CTL;
            pend_mode <= uemr_pkg::MODE_DISABLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (token_valid_i && dec_wait) begin
                        state <= ST_WAIT_ACK;
                        pend_ep <= token_i.ep;
                        pend_mode <= dec_ack_mode;
                    end
                end
                ST_WAIT_ACK: begin
                    if (token_valid_i) begin
                        state <= dec_wait ? ST_WAIT_ACK : ST_IDLE;
                        pend_ep <= token_i.ep;
                        pend_mode <= dec_ack_mode;
                    end else if (host_ack_i) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==================================================
    // Mode register writes
    logic eng_we_ctl;
    logic eng_we_a;
    logic eng_we_b;
    logic [3:0] eng_mode;
    logic data_upd;
    logic fw_we_ctl;
    logic fw_we_a;
    logic fw_we_b;

    always_comb begin
        eng_we_ctl = 1'b0;
        eng_we_a = 1'b0;
        eng_we_b = 1'b0;
        eng_mode = dec_upd_mode;
        if (token_valid_i && dec_upd) begin
            eng_we_ctl = (token_i.ep == uemr_pkg::EP_CTL);
            eng_we_a = (token_i.ep == uemr_pkg::EP_A);
            eng_we_b = (token_i.ep == uemr_pkg::EP_B);
        end else if (ack_fire) begin
            eng_mode = pend_mode;
            eng_we_ctl = (pend_ep == uemr_pkg::EP_CTL);
            eng_we_a = (pend_ep == uemr_pkg::EP_A);
            eng_we_b = (pend_ep == uemr_pkg::EP_B);
        end
    end

    assign data_upd = eng_we_a || eng_we_b;
    assign fw_we_ctl = io_wr_i && (io_addr_i == uemr_pkg::ADDR_CTL_MODE);
    assign fw_we_a = io_wr_i && (io_addr_i == uemr_pkg::ADDR_A_MODE) && !data_upd;
    assign fw_we_b = io_wr_i && (io_addr_i == uemr_pkg::ADDR_B_MODE) && !data_upd;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctl_mode <= uemr_pkg::MODE_REG_RESET;
        end else if (eng_we_ctl) begin
            ctl_mode <= {ctl_mode[7:4], eng_mode};
        end else if (fw_we_ctl) begin
            ctl_mode <= io_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            a_mode <= uemr_pkg::MODE_REG_RESET;
        end else if (eng_we_a) begin
            a_mode <= {a_mode[7:4], eng_mode};
        end else if (fw_we_a) begin
            a_mode <= io_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            b_mode <= uemr_pkg::MODE_REG_RESET;
        end else if (eng_we_b) begin
            b_mode <= {b_mode[7:4], eng_mode};
        end else if (fw_we_b) begin
            b_mode <= io_wdata_i;
        end
    end

    assign ctl_mode_o = ctl_mode;
    assign a_mode_o = a_mode;
    assign b_mode_o = b_mode;

    // ==================================================
    // Buffer address decode, I/O space only
    logic cpu_buf_hit;
    logic [1:0] cpu_ep;
    logic [2:0] cpu_idx;
    logic [7:0] cpu_buf_rdata;
    logic [7:0] eng_buf_rdata;

    always_comb begin
        cpu_buf_hit = 1'b1;
        cpu_ep = uemr_pkg::EP_CTL;
        cpu_idx = io_addr_i[2:0];
        if (io_addr_i >= uemr_pkg::ADDR_CTL_BUF && io_addr_i < uemr_pkg::ADDR_A_BUF) begin
            cpu_ep = uemr_pkg::EP_CTL;
        end else if (io_addr_i >= uemr_pkg::ADDR_A_BUF && io_addr_i < uemr_pkg::ADDR_B_BUF) begin
            cpu_ep = uemr_pkg::EP_A;
        end else if (io_addr_i >= uemr_pkg::ADDR_B_BUF
                     && io_addr_i < uemr_pkg::ADDR_B_BUF + 8'(DEPTH)) begin
            cpu_ep = uemr_pkg::EP_B;
        end else begin
            cpu_buf_hit = 1'b0;
        end
    end

    uemr_buf #(
        .DEPTH(DEPTH),
        .NUM(uemr_pkg::NUM_EP)
    ) u_buf (
        .clk_i(clk_i),
        .cpu_we_i(io_wr_i && cpu_buf_hit),
        .cpu_addr_i(buf_addr(cpu_ep, cpu_idx)),
        .cpu_wdata_i(io_wdata_i),
        .cpu_rdata_o(cpu_buf_rdata),
        .eng_we_i(rx_we_i),
        .eng_waddr_i(buf_addr(rx_ep_i, rx_idx_i)),
        .eng_wdata_i(rx_data_i),
        .eng_raddr_i(buf_addr(tx_ep_i, tx_idx_i)),
        .eng_rdata_o(eng_buf_rdata)
    );

    // ==================================================
    // Read data
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata_o <= uemr_pkg::RDATA_UNMAPPED;
        end else if (io_rd_i) begin
            if (io_addr_i == uemr_pkg::ADDR_CTL_MODE) begin
                io_rdata_o <= ctl_mode;
            end else if (io_addr_i == uemr_pkg::ADDR_A_MODE) begin
                io_rdata_o <= a_mode;
            end else if (io_addr_i == uemr_pkg::ADDR_B_MODE) begin
                io_rdata_o <= b_mode;
            end else if (cpu_buf_hit) begin
                io_rdata_o <= cpu_buf_rdata;
            end else begin
                io_rdata_o <= uemr_pkg::RDATA_UNMAPPED;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_o <= uemr_pkg::RDATA_UNMAPPED;
        end else begin
            tx_data_o <= eng_buf_rdata;
        end
    end

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    a_disable_ignores: assert property (token_valid_i && sel_mode == uemr_pkg::MODE_DISABLE
        |=> resp_valid_o && resp_o.code == uemr_pkg::RSP_NONE)
        else $error("disabled endpoint answered");
    a_ctl_nak_in: assert property (token_valid_i && token_i.ep == uemr_pkg::EP_CTL
        && token_i.kind == uemr_pkg::TOK_IN && sel_mode == uemr_pkg::MODE_NAK_IN_OUT
        |=> resp_o.code == uemr_pkg::RSP_NAK)
        else $error("control IN not NAKed");
    a_status_stall_in: assert property (token_valid_i && token_i.ep == uemr_pkg::EP_CTL
        && token_i.kind == uemr_pkg::TOK_IN && sel_mode == uemr_pkg::MODE_STATUS_OUT
        |=> resp_o.code == uemr_pkg::RSP_STALL && ctl_mode[3:0] == uemr_pkg::MODE_STALL_IN_OUT)
        else $error("status-out IN not stalled");
    a_empty_in: assert property (token_valid_i && token_i.ep == uemr_pkg::EP_CTL
        && token_i.kind == uemr_pkg::TOK_IN && sel_mode == uemr_pkg::MODE_STATUS_IN
        |=> resp_o.code == uemr_pkg::RSP_EMPTY && resp_o.count == uemr_pkg::NO_COUNT)
        else $error("empty packet not sent");
    a_counted_in: assert property (token_valid_i && dec_rsp == uemr_pkg::RSP_DATA
        |=> resp_o.count == $past(sel_count))
        else $error("wrong IN byte count");
    a_setup_ack: assert property (token_valid_i && token_i.ep == uemr_pkg::EP_CTL
        && token_i.kind == uemr_pkg::TOK_SETUP && token_i.dval
        && token_i.len <= uemr_pkg::MAX_PKT_LEN && sel_mode == uemr_pkg::MODE_STALL_IN_OUT
        |=> resp_o.code == uemr_pkg::RSP_ACK && ctl_mode[3:0] == uemr_pkg::MODE_NAK_IN_OUT)
        else $error("SETUP not acknowledged");
    a_data_setup: assert property (token_valid_i && token_i.ep != uemr_pkg::EP_CTL
        && token_i.kind == uemr_pkg::TOK_SETUP
        |=> resp_o.code == uemr_pkg::RSP_NONE && $stable(a_mode) && $stable(b_mode))
        else $error("data endpoint reacted to SETUP");
    a_out_ack_mode: assert property (token_valid_i && token_i.ep == uemr_pkg::EP_A
        && token_i.kind == uemr_pkg::TOK_OUT && token_i.dval
        && token_i.len <= uemr_pkg::MAX_PKT_LEN && a_mode[3:0] == uemr_pkg::MODE_ACK_OUT
        && !a_mode[uemr_pkg::STALL_BIT]
        |=> resp_o.code == uemr_pkg::RSP_ACK && a_mode[3:0] == uemr_pkg::MODE_NAK_OUT)
        else $error("OUT ACK did not move mode");
    a_in_ack_mode: assert property (token_valid_i && token_i.ep == uemr_pkg::EP_B
        && token_i.kind == uemr_pkg::TOK_IN && b_mode[3:0] == uemr_pkg::MODE_ACK_IN
        && !b_mode[uemr_pkg::STALL_BIT]
        ##1 (host_ack_i && !token_valid_i && !fw_we_b)
        |=> b_mode[3:0] == uemr_pkg::MODE_NAK_IN)
        else $error("host ACK did not move mode");
    a_fw_blocked: assert property (io_wr_i && io_addr_i == uemr_pkg::ADDR_B_MODE
        && eng_we_a |=> $stable(b_mode))
        else $error("firmware write not blocked");
    a_engine_wins: assert property (eng_we_ctl && fw_we_ctl
        |=> ctl_mode[3:0] == $past(eng_mode))
        else $error("firmware beat engine");
    a_bad_status: assert property (token_valid_i && token_i.ep == uemr_pkg::EP_CTL
        && token_i.kind == uemr_pkg::TOK_OUT && sel_mode == uemr_pkg::MODE_ACK_IN_STATUS_OUT
        && token_i.dval && token_i.len == uemr_pkg::ZERO_LEN_PKT && !token_i.toggle
        |=> resp_o.code == uemr_pkg::RSP_STALL)
        else $error("bad status acknowledged");

    c_setup: cover property (token_valid_i && token_i.kind == uemr_pkg::TOK_SETUP
        ##1 resp_o.code == uemr_pkg::RSP_ACK);
    c_in_done: cover property (state == ST_WAIT_ACK && ack_fire);
    c_blocked: cover property (io_wr_i && io_addr_i == uemr_pkg::ADDR_B_MODE && eng_we_a);
endmodule

// file: uemr_host.sv
`timescale 1ns/10ps
// ========================================
// Host token source
module uemr_host (
    // Clock
    input wire logic clk_i,
    // Token and handshake
    output logic tv_o,
    output uemr_pkg::uemr_token_type tok_o,
    output logic ack_o
);
    initial begin
        tv_o = 0;
        tok_o = '0;
        ack_o = 0;
    end
    // Token lines show junk once released
    task send(input logic [1:0] k, e, input logic [4:0] n, input logic t);
        tok_o = {k, e, n, 1'b1, t};
        tv_o = 1;
        @(negedge clk_i) tv_o = 0;
        tok_o = ~tok_o;
    endtask
    task ack();
        ack_o = 1;
        @(negedge clk_i) ack_o = 0;
        @(negedge clk_i);
    endtask
endmodule

// file: tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb;
    logic clk_i = 0, nrst_i = 0, io_wr_i = 0, io_rd_i = 0, rx_we_i = 0;
    logic token_valid_i, host_ack_i, resp_valid_o;
    logic [7:0] io_addr_i = 0, io_wdata_i = 0, rx_data_i = 0, io_rdata_o, tx_data_o, r;
    logic [3:0] ctl_count_i = 0, a_count_i = 0, b_count_i = 0;
    logic [2:0] rx_idx_i = 3, tx_idx_i = 0;
    uemr_pkg::uemr_ep_type rx_ep_i = uemr_pkg::EP_A, tx_ep_i = uemr_pkg::EP_CTL;
    uemr_pkg::uemr_token_type token_i;
    uemr_pkg::uemr_answer_type resp_o;
    uemr_pkg::uemr_rsp_type e;
    logic [3:0] ec;
    logic [7:0] ctl_mode_o, a_mode_o, b_mode_o, mem [24];
    logic [31:0] seed = 32'hb51d_d58f;
    int err_total = 0, n_checks = 0;
    uemr_top u_dut (.*);
    uemr_host u_host (.clk_i(clk_i), .tv_o(token_valid_i), .tok_o(token_i), .ack_o(host_ack_i));
    initial forever #12.5 clk_i = ~clk_i;
    // ========================================
    // Helpers
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function uemr_pkg::uemr_rsp_type ex(bit d, int m, int k);
        if (k == 0) return (!d && m inside {1, 2, 3, 6, 11, 15}) ? uemr_pkg::RSP_ACK
            : uemr_pkg::RSP_NONE;
        if (d) return m == (k == 1 ? 12 : 8) ? uemr_pkg::RSP_NAK : m == (k == 1 ? 13 : 9) ?
            (k == 1 ? uemr_pkg::RSP_DATA : uemr_pkg::RSP_ACK) : uemr_pkg::RSP_NONE;
        if (m == 1) return uemr_pkg::RSP_NAK;
        if (k == 1) return m inside {2, 3} ? uemr_pkg::RSP_STALL : m inside {6, 11} ?
            uemr_pkg::RSP_EMPTY : m == 15 ? uemr_pkg::RSP_DATA : uemr_pkg::RSP_NONE;
        return m inside {3, 6} ? uemr_pkg::RSP_STALL : m inside {2, 11, 15} ?
            uemr_pkg::RSP_ACK : uemr_pkg::RSP_NONE;
    endfunction
    task wr(input logic [7:0] a, d);
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1;
        @(negedge clk_i) io_wr_i = 0;
        @(negedge clk_i);
    endtask
    task rd(input logic [7:0] a);
        io_addr_i = a;
        io_rd_i = 1;
        @(negedge clk_i) io_rd_i = 0;
        r = io_rdata_o;
        @(negedge clk_i);
    endtask
    task wr_tok(input logic [7:0] a, d, input logic [1:0] k, ep);
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = 1;
        u_host.send(k, ep, 5'h02, 1'b1);
        io_wr_i = 0;
        @(negedge clk_i);
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #50000 err_total++;
        stop_test();
    end
    // ========================================
    // Tests
    initial begin
        repeat (2) @(negedge clk_i);
        nrst_i = 1;
        repeat (3) @(negedge clk_i);
        for (int i = 0; i < 24; i++) begin
            mem[i] = rnd();
            wr(uemr_pkg::ADDR_CTL_BUF + 8'(i), mem[i]);
        end
        rx_data_i = rnd();
        mem[11] = rx_data_i;
        rx_we_i = 1;
        @(negedge clk_i) rx_we_i = 0;
        for (int i = 0; i < 24; i++) begin
            rd(8'h50 + 8'(i));
            `CHK(r, mem[i])
        end
        `CHK(tx_data_o, mem[0])
        rd(8'h68);
        `CHK(r, uemr_pkg::RDATA_UNMAPPED)
        $display("test buffers done");
        for (int d = 0; d < 2; d++) for (int m = 0; m < 16; m++) for (int k = 0; k < 3; k++) begin
            if (d ? m inside {1, 2, 3, 6, 11, 15} : m inside {8, 9, 12, 13}) continue;
            ctl_count_i = 4'(rnd());
            a_count_i = 4'(rnd());
            e = ex(d, m, k);
            ec = (e == uemr_pkg::RSP_DATA) ? (d ? a_count_i : ctl_count_i) : 4'h0;
            wr(d ? uemr_pkg::ADDR_A_MODE : uemr_pkg::ADDR_CTL_MODE, 8'(m));
            u_host.send(2'(k), 2'(d), 5'h02, 1'b1);
            `CHK(resp_valid_o, 1'b1)
            `CHK(resp_o.code, e)
            `CHK(resp_o.count, ec)
        end
        $display("test modes done");
        wr(uemr_pkg::ADDR_CTL_MODE, 8'h0F);
        u_host.send(2'h2, 2'h0, 5'h02, 1'b0);
        `CHK(resp_o.code, uemr_pkg::RSP_STALL)
        `CHK(ctl_mode_o[3:0], uemr_pkg::MODE_STALL_IN_OUT)
        wr(uemr_pkg::ADDR_CTL_MODE, 8'h0F);
        u_host.send(2'h1, 2'h0, 5'h00, 1'b0);
        u_host.ack();
        `CHK(ctl_mode_o[3:0], uemr_pkg::MODE_NAK_IN_OUT)
        b_count_i = 4'h8;
        wr(uemr_pkg::ADDR_B_MODE, 8'h0D);
        u_host.send(2'h1, 2'h2, 5'h00, 1'b0);
        `CHK(resp_o.count, 4'h8)
        u_host.ack();
        `CHK(b_mode_o[3:0], uemr_pkg::MODE_NAK_IN)
        wr(uemr_pkg::ADDR_A_MODE, 8'h8D);
        u_host.send(2'h1, 2'h1, 5'h00, 1'b0);
        `CHK(resp_o.code, uemr_pkg::RSP_STALL)
        wr(uemr_pkg::ADDR_A_MODE, 8'h89);
        u_host.send(2'h2, 2'h1, 5'h02, 1'b1);
        `CHK(resp_o.code, uemr_pkg::RSP_STALL)
        $display("test handshakes done");
        wr(uemr_pkg::ADDR_A_MODE, 8'h09);
        wr(uemr_pkg::ADDR_B_MODE, 8'h00);
        wr_tok(uemr_pkg::ADDR_B_MODE, 8'h0C, 2'h2, 2'h1);
        `CHK(b_mode_o, 8'h00)
        `CHK(a_mode_o[3:0], uemr_pkg::MODE_NAK_OUT)
        wr(uemr_pkg::ADDR_CTL_MODE, 8'h03);
        wr_tok(uemr_pkg::ADDR_CTL_MODE, 8'h0F, 2'h0, 2'h0);
        `CHK(ctl_mode_o, 8'h01)
        rd(uemr_pkg::ADDR_B_MODE);
        if (r !== 8'h0C) wr(uemr_pkg::ADDR_B_MODE, 8'h0C);
        `CHK(b_mode_o, 8'h0C)
        $display("test arbitration done");
        stop_test();
    end
endmodule
